// ==== hdl/pmi_match_filter.sv ====
// pattern-match interrupt: persistence filter for the raw match level
// assumes the raw level is synchronous to mclk
`timescale 1ns/1ns
`include "pmi_regs.svh"

module pmi_match_filter #(
  parameter int HOLD = `PMI_MIN_HOLD_CLKS
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic raw_match,
  output logic      qualified
);
  logic [3:0] cnt_q;

  // qualified pulses for one clock once the level has been seen for more than HOLD clocks
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (!raw_match) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'(HOLD + 1)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      qualified <= 1'b0;
    end else begin
      qualified <= raw_match && (cnt_q == 4'(HOLD));
    end
  end

endmodule // pmi_match_filter

// ==== hdl/pmi_pkg.sv ====
// pattern-match interrupt: shared types
// assumes nothing beyond the header of constants
package pmi_pkg;
  typedef enum logic [1:0] {
    PMI_CMP_EQUAL    = 2'h0,
    PMI_CMP_NOTEQUAL = 2'h1
  } pmi_polarity_t;
endpackage : pmi_pkg

// ==== hdl/pmi_regs.svh ====
// pattern-match interrupt: register offsets, field positions, reset values, timing counts
// assumes a 32-bit ahb-lite slave, one aligned word per register
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define PMI_OFF_MASK     8'h00
`define PMI_OFF_PATTERN  8'h04
`define PMI_OFF_CONTROL  8'h08
`define PMI_OFF_STATUS   8'h0C
`define PMI_OFF_IRQMASK  8'h10
`define PMI_OFF_PORT     8'h14

// ************************************************************
// control register fields
// ************************************************************
`define PMI_CTL_FLAG     0
`define PMI_CTL_POL      1
`define PMI_CTL_IE       2
`define PMI_CTL_ACTIVE   3

// status / irq mask fields
`define PMI_ST_MATCH     0
`define PMI_ST_WAKE      1

// ************************************************************
// reset values
// ************************************************************
`define PMI_RST_MASK     8'h00
`define PMI_RST_PATTERN  8'h00
`define PMI_RST_CONTROL  4'h0
`define PMI_RST_IRQMASK  2'h0

// ************************************************************
// timing: a match must hold longer than this many cpu clocks
// ************************************************************
`define PMI_MIN_HOLD_CLKS 6

`endif

// ==== hdl/pmi_top.sv ====
// pattern-match interrupt on an 8-bit input port, ahb-lite register slave
// assumes port pins already synchronous to mclk; single 32-bit word transfers
`timescale 1ns/1ns
`include "pmi_regs.svh"

// Summary of operation
// R1: mask register picks which port pins may trigger a match.
// R2: pattern register compared continuously against live port levels.
// R3: polarity bit selects equal or not-equal as the match condition.
// R4: match flag in control sets on a match while the function is active.
// R5: interrupt requested while match flag and interrupt enable are both set.
// R6: pattern all ones with not-equal fires when any enabled pin goes low.
// R7: enabled match acts as a wake-up request for idle and power-down.
// R8: match must last more than six clocks; shorter matches are ignored.
// R9: pins with mask bit clear never affect the comparison.
// R10: flag stays set until software writes it clear; set again only by a new match.
module pmi_top #(
  parameter int PORT_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [PORT_W-1:0] port_in,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   pattern_match_interrupt,
  output logic                   wake_request,
  output logic                   irq
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [PORT_W-1:0] key_match_mask_q;
  logic [PORT_W-1:0] key_match_pattern_q;
  logic              key_match_flag_q;
  pmi_pkg::pmi_polarity_t pattern_polarity_select_q;
  logic              int_enable_q;
  logic              active_q;
  logic [1:0]        status_q;
  logic [1:0]        irq_mask_q;
  logic              wr_pend_q;
  logic [7:0]        addr_q;
  logic              raw_match;
  logic              qualified;
  logic              qual_prev_q;
  logic              match_event;
  logic              wr_ctl;
  logic              rd_status;
  logic [PORT_W-1:0] diff;

  // ************************************************************
  // ahb-lite slave: zero wait states, always okay
  // ************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      addr_q    <= haddr;
    end
  end

  assign wr_ctl    = wr_pend_q && (addr_q == `PMI_OFF_CONTROL);
  assign rd_status = hsel && htrans[1] && !hwrite && hready && (haddr == `PMI_OFF_STATUS);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      key_match_mask_q    <= PORT_W'(`PMI_RST_MASK);
      key_match_pattern_q <= PORT_W'(`PMI_RST_PATTERN);
      irq_mask_q          <= `PMI_RST_IRQMASK;
    end else if (wr_pend_q) begin
      if (addr_q == `PMI_OFF_MASK)    key_match_mask_q    <= hwdata[PORT_W-1:0]; // [R1]
      if (addr_q == `PMI_OFF_PATTERN) key_match_pattern_q <= hwdata[PORT_W-1:0]; // [R2]
      if (addr_q == `PMI_OFF_IRQMASK) irq_mask_q          <= hwdata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pattern_polarity_select_q <= pmi_pkg::PMI_CMP_EQUAL;
      int_enable_q              <= 1'b0;
      active_q                  <= 1'b0;
    end else if (wr_ctl) begin
      pattern_polarity_select_q <= hwdata[`PMI_CTL_POL] ? pmi_pkg::PMI_CMP_NOTEQUAL
                                                        : pmi_pkg::PMI_CMP_EQUAL; // [R3]
      int_enable_q              <= hwdata[`PMI_CTL_IE];
      active_q                  <= hwdata[`PMI_CTL_ACTIVE];
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      unique case (haddr)
        `PMI_OFF_MASK:    hrdata <= 32'(key_match_mask_q);
        `PMI_OFF_PATTERN: hrdata <= 32'(key_match_pattern_q);
        `PMI_OFF_CONTROL: hrdata <= 32'({active_q, int_enable_q,
                                          pattern_polarity_select_q[0], key_match_flag_q});
        `PMI_OFF_STATUS:  hrdata <= 32'(status_q | {1'b0, match_event}
                                         | {match_event & int_enable_q, 1'b0});
        `PMI_OFF_IRQMASK: hrdata <= 32'(irq_mask_q);
        `PMI_OFF_PORT:    hrdata <= 32'(port_in);
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // comparison and persistence
  // ************************************************************
  assign diff = (port_in ^ key_match_pattern_q) & key_match_mask_q; // [R9]
  // not-equal with pattern all ones means any enabled pin low matches
  assign raw_match = active_q &&
    ((pattern_polarity_select_q == pmi_pkg::PMI_CMP_NOTEQUAL) ? (diff != '0)
                                                              : (diff == '0)); // [R2] [R3] [R6]

  pmi_match_filter #(
    .HOLD (`PMI_MIN_HOLD_CLKS)
  ) u_filter (
    .mclk      (mclk),
    .rstn      (rstn),
    .raw_match (raw_match),
    .qualified (qualified)
  ); // [R8]

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      qual_prev_q <= 1'b0;
    end else begin
      qual_prev_q <= qualified;
    end
  end

  // only a fresh qualified match sets the flag again
  assign match_event = qualified && !qual_prev_q; // [R10]

  // set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      key_match_flag_q <= 1'b0;
    end else if (match_event) begin
      key_match_flag_q <= 1'b1; // [R4] [R6]
    end else if (wr_ctl && !hwdata[`PMI_CTL_FLAG]) begin
      key_match_flag_q <= 1'b0; // [R10]
    end
  end

  // ************************************************************
  // sticky status, cleared by read; event in the same cycle survives
  // ************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_q <= 2'h0;
    end else begin
      status_q <= (rd_status ? 2'h0 : status_q)
                | {match_event & int_enable_q, match_event};
    end
  end

  assign pattern_match_interrupt = key_match_flag_q && int_enable_q; // [R5]
  // wake stays up until the flag or the interrupt enable is cleared so a stopped core sees it
  assign wake_request = pattern_match_interrupt; // [R7]
  assign irq = |(status_q & irq_mask_q);

  // ************************************************************
  // assertions
  // ************************************************************
  property p_short_ignored;
    @(posedge mclk) disable iff (!rstn)
      (!raw_match ##1 raw_match [*6] ##1 !raw_match) |-> !match_event ##1 !match_event;
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("match set flag too early"); // [R8]

  property p_hold_sets;
    @(posedge mclk) disable iff (!rstn)
      (!raw_match ##1 raw_match [*7]) |=> ##1 key_match_flag_q;
  endproperty
  a_hold_sets: assert property (p_hold_sets) else $error("held match did not set flag"); // [R4]

  property p_irq_out;
    @(posedge mclk) disable iff (!rstn)
      $rose(pattern_match_interrupt) |-> $past(match_event) || $past(wr_ctl);
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt mismatch"); // [R5]

  property p_flag_sticky;
    @(posedge mclk) disable iff (!rstn)
      (key_match_flag_q && !wr_ctl) |=> key_match_flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without write"); // [R10]

  property p_masked_pins;
    @(posedge mclk) disable iff (!rstn)
      (key_match_mask_q == '0 && active_q) |->
        raw_match == (pattern_polarity_select_q == pmi_pkg::PMI_CMP_EQUAL);
  endproperty
  a_masked_pins: assert property (p_masked_pins) else $error("masked pins affect match"); // [R9]

  property p_notequal_low;
    @(posedge mclk) disable iff (!rstn)
      (active_q && key_match_pattern_q == '1 &&
       pattern_polarity_select_q == pmi_pkg::PMI_CMP_NOTEQUAL &&
       ((~port_in & key_match_mask_q) != '0)) |-> raw_match;
  endproperty
  a_notequal_low: assert property (p_notequal_low) else $error("low key not matched"); // [R6]

  property p_inactive;
    @(posedge mclk) disable iff (!rstn)
      !active_q [*8] |-> !qualified;
  endproperty
  a_inactive: assert property (p_inactive) else $error("match while inactive"); // [R4]

  property p_equal;
    @(posedge mclk) disable iff (!rstn)
      (active_q && pattern_polarity_select_q == pmi_pkg::PMI_CMP_EQUAL &&
       ((port_in & key_match_mask_q) == (key_match_pattern_q & key_match_mask_q)))
        |-> raw_match;
  endproperty
  a_equal: assert property (p_equal) else $error("equal match missed"); // [R2]

  property p_polarity;
    @(posedge mclk) disable iff (!rstn)
      (active_q && $past(active_q) && $stable(port_in) && $stable(key_match_pattern_q) &&
       $stable(key_match_mask_q) && $changed(pattern_polarity_select_q))
        |-> raw_match != $past(raw_match);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity ignored"); // [R3]

  property p_wake;
    @(posedge mclk) disable iff (!rstn)
      (match_event && int_enable_q && !wr_ctl) |=> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on match"); // [R7]

  property p_mask_reg;
    @(posedge mclk) disable iff (!rstn)
      (wr_pend_q && addr_q == `PMI_OFF_MASK) |=> key_match_mask_q == $past(hwdata[7:0]);
  endproperty
  a_mask_reg: assert property (p_mask_reg) else $error("mask write lost"); // [R1]

  // seven qualifying samples must precede every flag set
  property p_min_hold;
    @(posedge mclk) disable iff (!rstn)
      match_event |-> $past(raw_match, 1) && $past(raw_match, 2) && $past(raw_match, 3) &&
        $past(raw_match, 4) && $past(raw_match, 5) && $past(raw_match, 6) && $past(raw_match, 7);
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("flag set by a short match"); // [R8]

  property p_set_once;
    @(posedge mclk) disable iff (!rstn)
      (match_event ##1 raw_match [*8]) |-> !match_event;
  endproperty
  a_set_once: assert property (p_set_once) else $error("held match set flag twice"); // [R10]

  property p_flag_clear;
    @(posedge mclk) disable iff (!rstn)
      (wr_ctl && !hwdata[`PMI_CTL_FLAG] && !match_event) |=> !key_match_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write"); // [R10]

  property p_pattern_reg;
    @(posedge mclk) disable iff (!rstn)
      (wr_pend_q && addr_q == `PMI_OFF_PATTERN) |=>
        key_match_pattern_q == $past(hwdata[PORT_W-1:0]);
  endproperty
  a_pattern_reg: assert property (p_pattern_reg) else $error("pattern write lost"); // [R2]

  property p_ctl_reg;
    @(posedge mclk) disable iff (!rstn)
      wr_ctl |=> (active_q == $past(hwdata[`PMI_CTL_ACTIVE])) &&
                 (int_enable_q == $past(hwdata[`PMI_CTL_IE]));
  endproperty
  a_ctl_reg: assert property (p_ctl_reg) else $error("control write lost"); // [R4] [R5]

  property p_status_set;
    @(posedge mclk) disable iff (!rstn)
      match_event |=> status_q[`PMI_ST_MATCH] &&
        (status_q[`PMI_ST_WAKE] || !$past(int_enable_q));
  endproperty
  a_status_set: assert property (p_status_set) else $error("status missed a match"); // [R4] [R7]

  property p_status_clear;
    @(posedge mclk) disable iff (!rstn)
      (rd_status && !match_event) |=> status_q == 2'h0;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");

  property p_irq_rise;
    @(posedge mclk) disable iff (!rstn)
      $rose(irq) |-> $past(match_event) || $past(wr_pend_q);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without event or mask write");

endmodule // pmi_top

// ==== verification/pmi_key_model.sv ====
// keypad model driving the eight monitored port pins
// assumes press is called right after a rising edge of mclk
`timescale 1ns/1ns
module pmi_key_model (
  input  wire logic       mclk,
  output logic      [7:0] port_out
);
  // ********************
  // idle level and key presses
  // ********************
  // pull-ups hold released keys high
  initial port_out = 8'hFF;

  // holds a value for n cycles, then releases and lets the pins settle
  task automatic press(input logic [7:0] v, input int n);
    port_out <= v;
    repeat (n) @(posedge mclk);
    port_out <= 8'hFF;
    repeat (10) @(posedge mclk);
  endtask
endmodule // pmi_key_model

// ==== verification/port_pattern_match_interrupt_tb_top.sv ====
// self-checking bench for the port pattern-match interrupt block
// assumes pmi_key_model on the port and this bench as sole ahb-lite master
`timescale 1ns/1ns
`include "pmi_regs.svh"
module port_pattern_match_interrupt_tb_top;
  logic        mclk, rstn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  port_in, haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        pmi_irq, wake, irq;
  int          bad_count, samples_checked;

  pmi_key_model key (.mclk(mclk), .port_out(port_in));
  pmi_top uut (.mclk(mclk), .rstn(rstn), .port_in(port_in), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pattern_match_interrupt(pmi_irq), .wake_request(wake), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ********************
  // compare, bus access, verdict
  // ********************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single transfer; waits on hready in both phases, read data taken at the end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    summarize();
  end

  // ********************
  // scenarios
  // ********************
  initial begin
    {rstn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    bad_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdchk("mask", `PMI_OFF_MASK, 32'(`PMI_RST_MASK));
    rdchk("pattern", `PMI_OFF_PATTERN, 32'(`PMI_RST_PATTERN));
    rdchk("control", `PMI_OFF_CONTROL, 32'(`PMI_RST_CONTROL));
    rdchk("irqmask", `PMI_OFF_IRQMASK, 32'(`PMI_RST_IRQMASK));
    rdchk("port", `PMI_OFF_PORT, 32'hFF);
    bus(1'b1, 8'h18, 32'h5A);
    rdchk("unmapped", 8'h18, 32'h0);
    chk("hresp", 32'h0, 32'(hresp));
    // low nibble keys only, all-ones pattern, not-equal, function inactive
    bus(1'b1, `PMI_OFF_MASK, 32'h0F);
    bus(1'b1, `PMI_OFF_PATTERN, 32'hFF);
    bus(1'b1, `PMI_OFF_CONTROL, 32'h6);
    key.press(8'hFE, 20);
    rdchk("inactive", `PMI_OFF_CONTROL, 32'h6);
    bus(1'b1, `PMI_OFF_CONTROL, 32'hA);
    key.press(8'hEF, 20);
    rdchk("masked pin", `PMI_OFF_CONTROL, 32'hA);
    key.press(8'hFD, 6);
    rdchk("short press", `PMI_OFF_CONTROL, 32'hA);
    // seven samples: the shortest press that must count
    key.press(8'hFD, 7);
    rdchk("flag set", `PMI_OFF_CONTROL, 32'hB);
    #1;
    chk("irq no enable", 32'h0, 32'(pmi_irq));
    @(posedge mclk);
    bus(1'b1, `PMI_OFF_CONTROL, 32'hE);
    rdchk("flag clear", `PMI_OFF_CONTROL, 32'hE);
    key.press(8'hFB, 20);
    repeat (20) @(posedge mclk);
    #1;
    chk("match irq", 32'h1, 32'(pmi_irq));
    chk("wake", 32'h1, 32'(wake));
    chk("irq masked", 32'h0, 32'(irq));
    @(posedge mclk);
    bus(1'b1, `PMI_OFF_IRQMASK, 32'h1);
    #1;
    chk("irq raised", 32'h1, 32'(irq));
    @(posedge mclk);
    bus(1'b0, `PMI_OFF_STATUS, 32'h0);
    chk("status", 32'h3, 32'(rd[1:0]));
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    @(posedge mclk);
    // equal comparison on all pins
    bus(1'b1, `PMI_OFF_CONTROL, 32'h0);
    bus(1'b1, `PMI_OFF_PATTERN, 32'h05);
    bus(1'b1, `PMI_OFF_MASK, 32'hFF);
    bus(1'b1, `PMI_OFF_CONTROL, 32'hC);
    key.press(8'h04, 20);
    rdchk("near pattern", `PMI_OFF_CONTROL, 32'hC);
    key.press(8'h05, 20);
    rdchk("equal match", `PMI_OFF_CONTROL, 32'hD);
    // flip to not-equal while the port stands still; clear, then hold the match
    bus(1'b1, `PMI_OFF_CONTROL, 32'hE);
    repeat (12) @(posedge mclk);
    rdchk("polarity flip", `PMI_OFF_CONTROL, 32'hF);
    bus(1'b1, `PMI_OFF_CONTROL, 32'hE);
    repeat (12) @(posedge mclk);
    rdchk("held match once", `PMI_OFF_CONTROL, 32'hE);
    summarize();
  end
endmodule // port_pattern_match_interrupt_tb_top
